// *** src/dmau_regs.svh ***
// Purpose: constants for the data memory access unit
// Assumes: included by bare name
// Notes:   offsets, fields, reset values and timing counts
`ifndef DMAU_REGS_SVH
`define DMAU_REGS_SVH
`define DMAU_OFF_STATUS_WORD 32'h0000_008e
`define DMAU_OFF_PTR_HI    32'h0000_0083
`define DMAU_OFF_PTR_LO    32'h0000_0084
`define DMAU_OFF_AUX_CTRL  32'h0000_008c
`define DMAU_OFF_AUX_CTRL1 32'h0000_00a2
`define DMAU_OFF_HIPORT    32'h0000_00a0
`define DMAU_OFF_CMD       32'h0000_0100
`define DMAU_OFF_STAT      32'h0000_0104
`define DMAU_OFF_RAMWIN    32'h0000_0400
`define DMAU_RAMWIN_END    32'h0000_0c00
`define DMAU_OFF_XRAMWIN   32'h0000_2000
`define DMAU_STATUS_BANK_LSB 3
`define DMAU_AUX_LATCH     0
`define DMAU_AUX_XSEL      1
`define DMAU_AUX_SIZE_LSB  2
`define DMAU_AUX_STRETCH   5
`define DMAU_AUX1_PSEL     0
`define DMAU_AUX_RESET     8'h14
`define DMAU_PORT_RESET    8'hff
`define DMAU_CYCLE_CLKS    6
`define DMAU_STROBE_SHORT  3
`define DMAU_STROBE_LONG   15
`define DMAU_LATCH_PERIOD  6
`endif

// *** src/dmau_pkg.sv ***
// Purpose: types for the data memory access unit
// Assumes: nothing
// Notes:   state encoding of the external bus engine
package dmau_pkg;
  typedef enum logic [2:0] {
    DMAU_IDLE  = 3'b000,
    DMAU_ADDR  = 3'b001,
    DMAU_SETUP = 3'b010,
    DMAU_STRB  = 3'b011,
    DMAU_HOLD  = 3'b100
  } dmau_state_type;
endpackage

// *** src/dmau_top.sv ***
// Purpose: internal data memory, expanded ram and external data bus
// Assumes: AHB-Lite slave, word registers, one bus clock as cpu clock
// Notes:   RAM and commands reached through register windows
`timescale 1ns/1ps
`default_nettype none
`include "dmau_regs.svh"

// ---------------------------------------------
// module
// ---------------------------------------------
module dmau_top
  import dmau_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [7:0]  high_addr_port,
  output logic      [7:0]  low_addr_data_out,
  output logic             low_addr_data_oe,
  input  wire logic [7:0]  low_addr_data_in,
  output logic             addr_latch_strobe,
  output logic             read_strobe_n,
  output logic             write_strobe_n
);

  // ---------------------------------------------
  // storage and registers
  // ---------------------------------------------
  logic [7:0]  iram_reg [0:255];
  logic [7:0]  xpand_reg [0:2047];
  logic [7:0]  status_word_reg;
  logic [7:0]  aux_ctrl_reg;
  logic        psel_reg;
  logic [15:0] pointer_reg [0:1];
  logic [7:0]  hiport_reg;
  logic [7:0]  pin_s1_reg;
  logic [7:0]  pin_s2_reg;
  dmau_state_type state_reg;
  logic [4:0]  cnt_reg;
  logic [2:0]  latch_cnt_reg;
  logic        busy_reg;
  logic        xwr_reg;
  logic [15:0] xaddr_reg;
  logic [7:0]  xdata_reg;
  logic [7:0]  rdbyte_reg;

  // address phase capture
  logic        ap_valid_reg;
  logic        ap_write_reg;
  logic [31:0] ap_addr_reg;
  logic        ap_ok;
  assign ap_ok = hsel && hready && htrans[1];

  // ---------------------------------------------
  // functions
  // ---------------------------------------------
  function automatic logic [11:0] xpand_limit(input logic [2:0] code);
    case (code)
      3'b000:  xpand_limit = 12'h100;
      3'b001:  xpand_limit = 12'h200;
      3'b010:  xpand_limit = 12'h300;
      3'b011:  xpand_limit = 12'h400;
      3'b100:  xpand_limit = 12'h700;
      3'b101:  xpand_limit = 12'h800;
      default: xpand_limit = 12'h000;
    endcase
  endfunction

  // internal ram window and its word index
  function automatic logic in_ram_win(input logic [31:0] a);
    in_ram_win = (a >= `DMAU_OFF_RAMWIN) && (a < `DMAU_RAMWIN_END);
  endfunction

  function automatic logic [8:0] ram_index(input logic [31:0] a);
    logic [31:0] off;
    off = a - `DMAU_OFF_RAMWIN;
    ram_index = off[10:2];
  endfunction

  function automatic logic in_xpand_win(input logic [31:0] a);
    in_xpand_win = (a[31:13] == 19'(`DMAU_OFF_XRAMWIN >> 13));
  endfunction

  // direct access: upper half reaches function registers
  function automatic logic is_sfr(input logic [8:0] a);
    is_sfr = !a[8] && a[7];
  endfunction

  // command word: [7:0] low addr (high from hiport), [23:16] data, [24] write, [25] via pointer
  logic [31:0] wd;
  logic [8:0]  ramidx;
  logic        xpand_hit;
  logic [15:0] cmd_addr;
  logic [1:0]  bank_base;
  assign wd = hwdata;
  assign ramidx = ram_index(ap_addr_reg);
  assign bank_base = status_word_reg[`DMAU_STATUS_BANK_LSB +: 2];
  assign cmd_addr = wd[25] ? pointer_reg[psel_reg] : {hiport_reg, wd[7:0]};

  logic [15:0] stb_len;
  assign stb_len = aux_ctrl_reg[`DMAU_AUX_STRETCH] ? 16'(`DMAU_STROBE_LONG) : 16'(`DMAU_STROBE_SHORT);

  assign xpand_hit = !aux_ctrl_reg[`DMAU_AUX_XSEL] &&
                     ({4'h0, cmd_addr[11:0]} < {4'h0, xpand_limit(aux_ctrl_reg[`DMAU_AUX_SIZE_LSB +: 3])}) &&
                     (cmd_addr[15:12] == 4'h0);

  logic wr_hit;
  logic start;
  assign wr_hit = ap_valid_reg && ap_write_reg;
  assign start = wr_hit && ap_addr_reg == `DMAU_OFF_CMD && !busy_reg;

  // ---------------------------------------------
  // bus slave
  // ---------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= 32'h0000_0000;
    end else if (hreadyout) begin
      ap_valid_reg <= ap_ok;
      ap_write_reg <= hwrite;
      ap_addr_reg  <= haddr;
    end
  end

  // stall a command register write while an external cycle is in flight
  logic stall;
  assign stall = ap_valid_reg && busy_reg && (ap_addr_reg == `DMAU_OFF_CMD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      if (hreadyout) begin
        hreadyout <= !(ap_ok && hwrite && (busy_reg || start) && (haddr == `DMAU_OFF_CMD));
      end else begin
        hreadyout <= !stall;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // read data decode
  logic [31:0] rd_next;
  logic [8:0]  hidx;
  assign hidx = ram_index(haddr);
  always_comb begin
    rd_next = 32'h0000_0000;
    if (haddr == `DMAU_OFF_STATUS_WORD) begin
      rd_next = {24'h0, status_word_reg};
    end else if (haddr == `DMAU_OFF_AUX_CTRL) begin
      rd_next = {24'h0, 2'b00, aux_ctrl_reg[5:0]};
    end else if (haddr == `DMAU_OFF_AUX_CTRL1) begin
      rd_next = {31'h0, psel_reg};
    end else if (haddr == `DMAU_OFF_PTR_HI) begin
      rd_next = {24'h0, pointer_reg[psel_reg][15:8]};
    end else if (haddr == `DMAU_OFF_PTR_LO) begin
      rd_next = {24'h0, pointer_reg[psel_reg][7:0]};
    end else if (haddr == `DMAU_OFF_HIPORT) begin
      rd_next = {24'h0, hiport_reg};
    end else if (haddr == `DMAU_OFF_STAT) begin
      rd_next = {23'h0, busy_reg, rdbyte_reg};
    end else if (in_ram_win(haddr)) begin
      rd_next = {24'h0, iram_reg[hidx[7:0]]};
    end else if (in_xpand_win(haddr)) begin
      rd_next = {24'h0, xpand_reg[haddr[12:2]]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_ok && hreadyout) begin
      hrdata <= rd_next;
    end
  end

  // ---------------------------------------------
  // control registers
  // ---------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_word_reg <= 8'h00;
      aux_ctrl_reg    <= `DMAU_AUX_RESET;
      psel_reg        <= 1'b0;
      hiport_reg      <= `DMAU_PORT_RESET;
      pointer_reg[0]  <= 16'h0000;
      pointer_reg[1]  <= 16'h0000;
    end else if (wr_hit) begin
      if (ap_addr_reg == `DMAU_OFF_STATUS_WORD) begin
        status_word_reg <= wd[7:0];
      end else if (ap_addr_reg == `DMAU_OFF_AUX_CTRL) begin
        aux_ctrl_reg <= {2'b00, wd[5:0]};
      end else if (ap_addr_reg == `DMAU_OFF_AUX_CTRL1) begin
        psel_reg <= wd[`DMAU_AUX1_PSEL];
      end else if (ap_addr_reg == `DMAU_OFF_PTR_HI) begin
        pointer_reg[psel_reg][15:8] <= wd[7:0];
      end else if (ap_addr_reg == `DMAU_OFF_PTR_LO) begin
        pointer_reg[psel_reg][7:0] <= wd[7:0];
      end else if (ap_addr_reg == `DMAU_OFF_HIPORT) begin
        hiport_reg <= wd[7:0];
      end
    end
  end

  // ram window: index 0-255 indirect, 256-319 bank regs, 384+ bit writes
  always_ff @(posedge hclk) begin
    if (wr_hit && in_ram_win(ap_addr_reg)) begin
      if (!ramidx[8]) begin
        iram_reg[ramidx[7:0]] <= wd[7:0];
      end else if (ramidx[7:6] == 2'b00 && !is_sfr(ramidx)) begin
        iram_reg[{3'b000, bank_base, ramidx[2:0]}] <= wd[7:0];
      end else if (ramidx[7]) begin
        iram_reg[{4'h2, ramidx[6:3]}][ramidx[2:0]] <= wd[0];
      end
    end
  end

  // ---------------------------------------------
  // external bus engine
  // ---------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= low_addr_data_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  always_ff @(posedge hclk) begin
    if (start && xpand_hit && wd[24]) begin
      xpand_reg[cmd_addr[10:0]] <= wd[23:16];
    end else if (wr_hit && in_xpand_win(ap_addr_reg)) begin
      xpand_reg[ap_addr_reg[12:2]] <= wd[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= DMAU_IDLE;
      cnt_reg   <= 5'd0;
      busy_reg  <= 1'b0;
      xwr_reg   <= 1'b0;
      xaddr_reg <= 16'h0000;
      xdata_reg <= 8'h00;
      rdbyte_reg <= 8'h00;
    end else begin
      case (state_reg)
        DMAU_IDLE: begin
          if (start && xpand_hit) begin
            rdbyte_reg <= xpand_reg[cmd_addr[10:0]];
          end else if (start) begin
            state_reg <= DMAU_ADDR;
            busy_reg  <= 1'b1;
            xwr_reg   <= wd[24];
            xaddr_reg <= cmd_addr;
            xdata_reg <= wd[23:16];
          end
        end
        DMAU_ADDR: begin
          state_reg <= DMAU_SETUP;
        end
        DMAU_SETUP: begin
          state_reg <= DMAU_STRB;
          cnt_reg   <= stb_len[4:0];
        end
        DMAU_STRB: begin
          if (cnt_reg == 5'd1) begin
            state_reg <= DMAU_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 5'd1;
          end
        end
        DMAU_HOLD: begin
          state_reg <= DMAU_IDLE;
          busy_reg  <= 1'b0;
          if (!xwr_reg) begin
            rdbyte_reg <= pin_s2_reg;
          end
        end
        default: begin
          state_reg <= DMAU_IDLE;
        end
      endcase
    end
  end

  // pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_cnt_reg     <= 3'd0;
      addr_latch_strobe <= 1'b0;
      high_addr_port    <= `DMAU_PORT_RESET;
      low_addr_data_out <= 8'h00;
      low_addr_data_oe  <= 1'b0;
      read_strobe_n     <= 1'b1;
      write_strobe_n    <= 1'b1;
    end else begin
      latch_cnt_reg <= (latch_cnt_reg == 3'(`DMAU_LATCH_PERIOD - 1)) ? 3'd0 : latch_cnt_reg + 3'd1;
      if (state_reg == DMAU_ADDR) begin
        addr_latch_strobe <= 1'b1;
      end else if (!aux_ctrl_reg[`DMAU_AUX_LATCH] && !busy_reg) begin
        addr_latch_strobe <= (latch_cnt_reg == 3'd0);
      end else begin
        addr_latch_strobe <= 1'b0;
      end
      high_addr_port    <= busy_reg ? xaddr_reg[15:8] : hiport_reg;
      low_addr_data_out <= (state_reg == DMAU_ADDR) ? xaddr_reg[7:0] : xdata_reg;
      low_addr_data_oe  <= (state_reg == DMAU_ADDR) || (busy_reg && xwr_reg);
      read_strobe_n     <= !((state_reg == DMAU_STRB) && !xwr_reg);
      write_strobe_n    <= !((state_reg == DMAU_STRB) && xwr_reg);
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  property p_strobe_len;
    @(posedge hclk) disable iff (!hresetn)
    $fell(read_strobe_n) && !aux_ctrl_reg[`DMAU_AUX_STRETCH] |-> !read_strobe_n[*3] ##1 read_strobe_n;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("short strobe length wrong");

  property p_not_both;
    @(posedge hclk) disable iff (!hresetn)
    !(!read_strobe_n && !write_strobe_n);
  endproperty
  a_not_both: assert property (p_not_both) else $error("both strobes low");

  property p_latch_first;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == DMAU_ADDR) |=> addr_latch_strobe && low_addr_data_oe && low_addr_data_out == xaddr_reg[7:0];
  endproperty
  a_latch_first: assert property (p_latch_first) else $error("address not latched");

  property p_suppress;
    @(posedge hclk) disable iff (!hresetn)
    aux_ctrl_reg[`DMAU_AUX_LATCH] && $past(aux_ctrl_reg[`DMAU_AUX_LATCH]) && !busy_reg && !$past(busy_reg)
      |-> !addr_latch_strobe;
  endproperty
  a_suppress: assert property (p_suppress) else $error("latch strobe not suppressed");

  property p_size_reset;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> aux_ctrl_reg[4:2] == 3'b101;
  endproperty
  a_size_reset: assert property (p_size_reset) else $error("size reset wrong");

  property p_hi_port;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == DMAU_SETUP) |-> high_addr_port == xaddr_reg[15:8];
  endproperty
  a_hi_port: assert property (p_hi_port) else $error("high address wrong");

  property p_cycle_len;
    @(posedge hclk) disable iff (!hresetn)
    $rose(busy_reg) && !aux_ctrl_reg[`DMAU_AUX_STRETCH] |-> busy_reg[*6] ##1 !busy_reg;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");

  property p_beyond;
    @(posedge hclk) disable iff (!hresetn)
    start && !xpand_hit |=> busy_reg;
  endproperty
  a_beyond: assert property (p_beyond) else $error("external access not started");

endmodule
`default_nettype wire

// *** verification/dmau_ext_mem.sv ***
// Purpose: far-side model of the external data memory
// Assumes: latch strobe active high, strobes active low
// Notes:   read data is latched low address xor 3c
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// model
// ---------------------------------------------
module dmau_ext_mem (
  input  wire logic       hclk,
  input  wire logic       addr_latch_strobe,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [7:0] high_addr_port,
  input  wire logic [7:0] low_addr_data_out,
  input  wire logic       low_addr_data_oe,
  output var  logic [7:0] data_to_device,
  output var  logic [15:0] seen_addr,
  output var  logic [7:0] seen_wdata
);
  logic [7:0] lo_latched;

  initial begin
    lo_latched     = 8'h00;
    data_to_device = 8'h00;
    seen_addr      = 16'h0000;
    seen_wdata     = 8'h00;
  end
  // pins sampled where settled, low address taken while the latch stands
  always @(posedge hclk) begin
    if (addr_latch_strobe && low_addr_data_oe) begin
      lo_latched <= low_addr_data_out;
    end
    if (!read_strobe_n || !write_strobe_n) begin
      seen_addr <= {high_addr_port, lo_latched};
    end
    if (!write_strobe_n) begin
      seen_wdata <= low_addr_data_out;
    end
  end
  // released bus shows the inverse of the last value
  always @(read_strobe_n or lo_latched) begin
    if (!read_strobe_n) begin
      data_to_device = lo_latched ^ 8'h3c;
    end else begin
      data_to_device = ~data_to_device;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: self-checking bench for the data memory access unit
// Assumes: single AHB-Lite slave, hready from hreadyout
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "dmau_regs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb;
  import dmau_pkg::*;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, lo_oe, latch, rd_n, wr_n, latch_q;
  logic [7:0]  hi_port, lo_out, lo_in, mem_drv, seen_wdata, low_cnt, last_width;
  logic [15:0] seen_addr;
  int          fail_count, checked, strobes, latches, s0;

  dmau_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .high_addr_port(hi_port), .low_addr_data_out(lo_out),
    .low_addr_data_oe(lo_oe), .low_addr_data_in(lo_in), .addr_latch_strobe(latch),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n));
  dmau_ext_mem mem (.hclk(hclk), .addr_latch_strobe(latch), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .high_addr_port(hi_port), .low_addr_data_out(lo_out), .low_addr_data_oe(lo_oe),
    .data_to_device(mem_drv), .seen_addr(seen_addr), .seen_wdata(seen_wdata));
  assign lo_in = lo_oe ? lo_out : mem_drv;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ---------------------------------------------
  // strobe and latch monitors
  // ---------------------------------------------
  always @(posedge hclk) begin
    latch_q <= latch;
    if (latch && !latch_q) latches++;
    if (!rd_n || !wr_n) begin
      low_cnt <= low_cnt + 8'h01;
    end else if (low_cnt != 8'h00) begin
      last_width <= low_cnt;
      low_cnt <= 8'h00;
      strobes++;
    end
  end
  // ---------------------------------------------
  // bus tasks
  // ---------------------------------------------
  task finish_test;
    $display("counts: checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task wait_ready;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 100);
    if (i >= 100) begin
      fail_count++;
      finish_test;
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= 3'b010;
    wait_ready;
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask
  task run_cmd(input logic [31:0] c);
    int i;
    ahb(1'b1, `DMAU_OFF_CMD, c);
    i = 0;
    do begin
      ahb(1'b0, `DMAU_OFF_STAT, 32'h0);
      i++;
    end while (rd[8] !== 1'b0 && i < 100);
    if (i >= 100) begin
      fail_count++;
      finish_test;
    end
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_reset;
    ahb(1'b0, `DMAU_OFF_AUX_CTRL, 32'h0);
    `CHK("aux ctrl", 32'h0000_0014, rd)
    `CHK("hresp", 1'b0, hresp)
    `CHK("high port", 8'hff, hi_port)
    `CHK("strobes", 2'b11, {rd_n, wr_n})
    ahb(1'b0, 32'h0000_1000, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
  endtask
  task t_ram;
    ahb(1'b1, `DMAU_OFF_RAMWIN + 32'h214, 32'h0000_00c3);
    ahb(1'b0, `DMAU_OFF_RAMWIN + 32'h214, 32'h0);
    `CHK("upper ram", 32'h0000_00c3, rd)
    ahb(1'b1, `DMAU_OFF_STATUS_WORD, 32'h0000_0010);
    ahb(1'b1, `DMAU_OFF_RAMWIN + 32'h40c, 32'h0000_005e);
    ahb(1'b0, `DMAU_OFF_RAMWIN + 32'h04c, 32'h0);
    `CHK("bank 2 r3", 32'h0000_005e, rd)
    ahb(1'b1, `DMAU_OFF_RAMWIN + 32'h084, 32'h0000_0000);
    ahb(1'b1, `DMAU_OFF_RAMWIN + 32'h628, 32'h0000_0001);
    ahb(1'b0, `DMAU_OFF_RAMWIN + 32'h084, 32'h0);
    `CHK("bit 0a", 32'h0000_0004, rd)
    $display("test ram done");
  endtask
  task t_latch;
    @(posedge hclk);
    #1 latches = 0;
    repeat (60) @(posedge hclk);
    `CHK("free latch", 10, latches)
    ahb(1'b1, `DMAU_OFF_AUX_CTRL, 32'h0000_0015);
    @(posedge hclk);
    #1 latches = 0;
    repeat (60) @(posedge hclk);
    `CHK("quiet latch", 0, latches)
    $display("test latch done");
  endtask
  task t_ext_write;
    ahb(1'b1, `DMAU_OFF_AUX_CTRL, 32'h0000_0016);
    ahb(1'b1, `DMAU_OFF_PTR_HI, 32'h0000_0012);
    ahb(1'b1, `DMAU_OFF_PTR_LO, 32'h0000_0034);
    run_cmd(32'h035a_0000);
    `CHK("wr addr", 16'h1234, seen_addr)
    `CHK("wr data", 8'h5a, seen_wdata)
    `CHK("wr width", 8'h03, last_width)
    $display("test external write done");
  endtask
  task t_ext_read;
    ahb(1'b1, `DMAU_OFF_AUX_CTRL, 32'h0000_0036);
    ahb(1'b1, `DMAU_OFF_HIPORT, 32'h0000_0077);
    run_cmd(32'h0000_0021);
    `CHK("rd addr", 16'h7721, seen_addr)
    `CHK("rd data", 8'h1d, rd[7:0])
    `CHK("rd width", 8'h0f, last_width)
    $display("test external read done");
  endtask
  task t_expanded_ram;
    ahb(1'b1, `DMAU_OFF_AUX_CTRL, 32'h0000_0014);
    ahb(1'b1, `DMAU_OFF_XRAMWIN + 32'h40, 32'h0000_00a7);
    ahb(1'b1, `DMAU_OFF_PTR_HI, 32'h0000_0000);
    ahb(1'b1, `DMAU_OFF_PTR_LO, 32'h0000_0010);
    s0 = strobes;
    run_cmd(32'h0200_0000);
    `CHK("xpand data", 8'ha7, rd[7:0])
    `CHK("xpand no bus", s0, strobes)
    ahb(1'b1, `DMAU_OFF_AUX_CTRL, 32'h0000_0000);
    ahb(1'b1, `DMAU_OFF_PTR_HI, 32'h0000_0001);
    ahb(1'b1, `DMAU_OFF_PTR_LO, 32'h0000_0050);
    run_cmd(32'h0200_0000);
    `CHK("beyond size", 16'h0150, seen_addr)
    `CHK("beyond strobe", s0 + 1, strobes)
    $display("test expanded ram done");
  endtask
  task t_data_pointer;
    ahb(1'b1, `DMAU_OFF_AUX_CTRL1, 32'h0000_0001);
    ahb(1'b1, `DMAU_OFF_PTR_LO, 32'h0000_0099);
    ahb(1'b1, `DMAU_OFF_AUX_CTRL1, 32'h0000_0000);
    ahb(1'b0, `DMAU_OFF_PTR_LO, 32'h0);
    `CHK("pointer 0", 32'h0000_0050, rd)
    ahb(1'b1, `DMAU_OFF_AUX_CTRL1, 32'h0000_0001);
    ahb(1'b0, `DMAU_OFF_PTR_LO, 32'h0);
    `CHK("pointer 1", 32'h0000_0099, rd)
    $display("test dual pointer done");
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; latch_q = 1'b0; low_cnt = 8'h00; last_width = 8'h00;
    fail_count = 0; checked = 0; strobes = 0; latches = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_ram;
    t_latch;
    t_ext_write;
    t_ext_read;
    t_expanded_ram;
    t_data_pointer;
    finish_test;
  end
endmodule
`default_nettype wire
